// >>> hw/rco_receive_out.sv
/*
 * Receive-side outputs of an eight-channel T1/E1 line interface: recovered
 * clock, rail data, loss-of-signal flags and the host wait enable.
 * Assumes sliced line pulses arrive synchronous to i_ref_clk and the master
 * reference clock is sampled as an ordinary level.
 */
// Operation
// [RULE1] Clock recovery mode: recovered_clock_out carries each channel's recovered line clock.
// [RULE2] Data launches on rising clock edge if clock_edge_select high, else falling.
// [RULE3] Data recovery mode: recovered_clock_out is XOR of both rail outputs.
// [RULE4] Powered-down receiver puts its recovered_clock_out in high impedance.
// [RULE5] Master reference clock is free running, 1.544 or 2.048 MHz, from outside.
// [RULE6] Master reference held high: raw sliced return-to-zero pulses, no retiming.
// [RULE7] Master reference held low: all receivers off, clock and rails high impedance.
// [RULE8] No host wait states on host_wait_ack without master reference clock.
// [RULE9] signal_loss_flag rises on no transitions or too low ones density.
// [RULE10] signal_loss_flag falls by itself once enough ones seen over interval.
// [RULE11] Data recovery rails active low with clock_edge_select low, else high.
// [RULE12] Loss interval and ones-density threshold are parameters.
module rco_receive_out
    import rco_pkg::*;
#(
    parameter int BIT_CYC     = rco_pkg::BIT_CYCLES,
    parameter int ZERO_BITS   = rco_pkg::LOS_ZERO_BITS,
    parameter int WIN_BITS    = rco_pkg::LOS_WIN_BITS,
    parameter int ONES_MIN    = rco_pkg::LOS_ONES_MIN,
    parameter int FIFO_WORDS  = rco_pkg::FIFO_DEPTH
) (
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_rst_n,
    input  wire logic                         i_master_reference_clock,
    input  wire logic                         i_clock_edge_select,
    input  wire logic [rco_pkg::CH_COUNT-1:0] i_line_pos,
    input  wire logic [rco_pkg::CH_COUNT-1:0] i_line_neg,
    input  wire logic                         i_host_wait_req,
    output logic [rco_pkg::CH_COUNT-1:0]      o_recovered_clock_out,
    output logic [rco_pkg::CH_COUNT-1:0]      o_recovered_clock_oe,
    output logic [rco_pkg::CH_COUNT-1:0]      o_positive_rail_data,
    output logic [rco_pkg::CH_COUNT-1:0]      o_positive_rail_oe,
    output logic [rco_pkg::CH_COUNT-1:0]      o_negative_rail_data,
    output logic [rco_pkg::CH_COUNT-1:0]      o_negative_rail_oe,
    output logic [rco_pkg::CH_COUNT-1:0]      o_signal_loss_flag,
    output logic                              o_host_wait_ack
);
    import rco_pkg::*;

    localparam int PW = $clog2(BIT_CYC);
    localparam int MW = $clog2(MCLK_LOSS_CYCLES + 1);
    localparam int ZW = $clog2(ZERO_BITS + 1);
    localparam int WW = $clog2(WIN_BITS + 1);

    localparam logic [PW-1:0] PH_LAST   = PW'(BIT_CYC - 1);
    localparam logic [PW-1:0] PH_HALF   = PW'(BIT_CYC / 2);
    localparam logic [PW-1:0] PH_SAMPLE = PW'((BIT_CYC * 3) / 4);
    localparam logic [MW-1:0] MCLK_LIM  = MW'(MCLK_LOSS_CYCLES);
    localparam logic [ZW-1:0] ZERO_LIM  = ZW'(ZERO_BITS);
    localparam logic [WW-1:0] WIN_LIM   = WW'(WIN_BITS);
    localparam logic [WW-1:0] ONES_LIM  = WW'(ONES_MIN);

    if (BIT_CYC < 4 || ZERO_BITS < 1 || WIN_BITS < 1 || ONES_MIN < 1
        || ONES_MIN > WIN_BITS) begin : g_bad_param
        $error("rco_receive_out: unusable bit period or loss parameters");
    end

    function automatic logic [CH_W-1:0] rco_first(input logic [CH_COUNT-1:0] v);
        logic [CH_W-1:0] r;
        r = '0;
        for (int i = CH_COUNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = CH_W'(i);
            end
        end
        return r;
    endfunction : rco_first

    // Master reference supervision
    logic            mclk_prev;
    logic [MW-1:0]   mclk_quiet;
    rco_mode_t       mode;

    wire             mclk_edge    = i_master_reference_clock ^ mclk_prev;
    wire             mclk_running = (mclk_quiet < MCLK_LIM);
    rco_mode_t       next_mode;

    // Ref clock presence, else its held level, chooses the receive mode
    assign next_mode = mclk_running             ? RCO_CLOCK_REC :
                       i_master_reference_clock ? RCO_DATA_REC  :
                                                  RCO_POWER_DOWN;  // [RULE6] [RULE7]

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            mclk_prev       <= 1'b0;
            mclk_quiet      <= MCLK_LIM;
            mode            <= RCO_POWER_DOWN;
            o_host_wait_ack <= 1'b0;
        end else begin
            mclk_prev       <= i_master_reference_clock;
            mclk_quiet      <= mclk_edge ? '0 :
                               (mclk_running ? mclk_quiet + MW'(1) : mclk_quiet);
            mode            <= next_mode;
            o_host_wait_ack <= i_host_wait_req & mclk_running;  // [RULE8]
        end
    end

    // Recovered-bit buffer between sampling and the output launch
    logic [CH_COUNT-1:0] pend;
    logic [CH_COUNT-1:0] pend_p;
    logic [CH_COUNT-1:0] pend_n;
    logic [CH_COUNT-1:0] launch;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic [WORD_W-1:0]   fifo_out_data;

    wire [CH_W-1:0]   grant    = rco_first(pend);
    wire [WORD_W-1:0] fifo_in  = {grant, pend_p[grant], pend_n[grant]};
    wire [CH_W-1:0]   head_ch  = fifo_out_data[WORD_W-1:2];
    wire              head_p   = fifo_out_data[1];
    wire              head_n   = fifo_out_data[0];
    wire              fifo_pop = fifo_out_valid & launch[head_ch];
    wire              recover  = (mode == RCO_CLOCK_REC);

    // Head waits for its own channel's launch edge, so a slow lane stalls all
    rco_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_WORDS)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_flush     (!recover),
        .i_in_valid  (|pend),
        .i_in_data   (fifo_in),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (fifo_out_valid),
        .o_out_data  (fifo_out_data),
        .i_out_ready (recover && launch[head_ch])
    );

    for (genvar g = 0; g < CH_COUNT; g++) begin : g_ch
        logic [PW-1:0] phase;
        logic          line_prev;
        logic          seen_p;
        logic          seen_n;
        logic          pnd;
        logic          pnd_p;
        logic          pnd_n;
        logic          rclk;
        logic          rdp;
        logic          rdn;
        logic          oe;
        logic [ZW-1:0] zero_run;
        logic [WW-1:0] win_cnt;
        logic [WW-1:0] ones_cnt;
        logic          los;

        wire line_any  = i_line_pos[g] | i_line_neg[g];
        wire realign   = line_any & ~line_prev;
        wire sample    = (phase == PH_SAMPLE);
        wire bit_one   = seen_p | seen_n;
        wire powered   = (mode != RCO_POWER_DOWN);
        wire taken     = pnd & fifo_in_ready & (grant == CH_W'(g));
        wire rclk_d    = (phase < PH_HALF);
        // Launch on the chosen edge of the recovered clock
        wire edge_hit  = (rclk_d != rclk) & (rclk_d == i_clock_edge_select);  // [RULE2]
        wire load_head = fifo_pop & (head_ch == CH_W'(g));
        wire win_end   = sample & (win_cnt == WIN_LIM - WW'(1));
        wire dens_ok   = ((ones_cnt + WW'(bit_one)) >= ONES_LIM);
        wire zero_hit  = sample & ~bit_one & (zero_run == ZERO_LIM - ZW'(1));

        // Raw slice, inverted while clock_edge_select is low
        wire raw_p     = i_line_pos[g] ^ ~i_clock_edge_select;  // [RULE6] [RULE11]
        wire raw_n     = i_line_neg[g] ^ ~i_clock_edge_select;  // [RULE11]

        wire next_rdp  = (mode == RCO_DATA_REC) ? raw_p : (load_head ? head_p : rdp);
        wire next_rdn  = (mode == RCO_DATA_REC) ? raw_n : (load_head ? head_n : rdn);
        wire next_rclk = (mode == RCO_DATA_REC) ? (next_rdp ^ next_rdn)  // [RULE3]
                                                : (recover & rclk_d);    // [RULE1]

        assign launch[g] = recover & edge_hit;
        assign pend[g]   = pnd;
        assign pend_p[g] = pnd_p;
        assign pend_n[g] = pnd_n;

        assign o_recovered_clock_out[g] = rclk;
        assign o_recovered_clock_oe[g]  = oe;   // [RULE4]
        assign o_positive_rail_data[g]  = rdp;
        assign o_positive_rail_oe[g]    = oe;
        assign o_negative_rail_data[g]  = rdn;
        assign o_negative_rail_oe[g]    = oe;
        assign o_signal_loss_flag[g]    = los;

        // Digital recovery: phase counter pulled to bit start on each pulse
        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n || !powered) begin
                phase     <= '0;
                line_prev <= 1'b0;
                seen_p    <= 1'b0;
                seen_n    <= 1'b0;
            end else begin
                line_prev <= line_any;
                phase     <= realign ? PW'(1) : (phase == PH_LAST ? '0 : phase + PW'(1));
                seen_p    <= (seen_p & ~sample) | i_line_pos[g];
                seen_n    <= (seen_n & ~sample) | i_line_neg[g];
            end
        end

        // New sample wins over a same-cycle hand-off to the buffer
        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n || !recover) begin
                pnd   <= 1'b0;
                pnd_p <= 1'b0;
                pnd_n <= 1'b0;
            end else begin
                pnd   <= sample | (pnd & ~taken);
                pnd_p <= sample ? seen_p : pnd_p;
                pnd_n <= sample ? seen_n : pnd_n;
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                rclk <= 1'b0;
                rdp  <= 1'b0;
                rdn  <= 1'b0;
                oe   <= 1'b0;
            end else begin
                rclk <= next_rclk;
                rdp  <= next_rdp;
                rdn  <= next_rdn;
                oe   <= (next_mode != RCO_POWER_DOWN);  // [RULE4] [RULE7]
            end
        end

        // Loss of signal: zero run or poor density over the window
        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                zero_run <= '0;
                win_cnt  <= '0;
                ones_cnt <= '0;
                los      <= 1'b0;
            end else if (sample) begin
                zero_run <= bit_one ? '0 : (zero_hit ? zero_run : zero_run + ZW'(1));
                win_cnt  <= win_end ? '0 : win_cnt + WW'(1);
                ones_cnt <= win_end ? '0 : ones_cnt + WW'(bit_one);
                if (zero_hit || (win_end && !dens_ok)) begin
                    los <= 1'b1;  // [RULE9] [RULE12]
                end else if (win_end && dens_ok && zero_run < ZERO_LIM) begin
                    los <= 1'b0;  // [RULE10] [RULE12]
                end
            end
        end
    end

endmodule : rco_receive_out

// >>> pkg/rco_pkg.sv
/*
 * Shared constants and types for the eight-channel receive clock, rail data
 * and loss-of-signal output block.
 * Assumes a 50 MHz internal reference clock and E1 line rate for timing.
 */
package rco_pkg;

    localparam int CH_COUNT         = 8;
    localparam int CH_W             = 3;

    // Timebase
    localparam int REF_CLK_HZ       = 50_000_000;
    localparam int CLK_PERIOD_NS    = 20;
    localparam int LINE_RATE_HZ     = 2_048_000;
    localparam int BIT_CYCLES       = REF_CLK_HZ / LINE_RATE_HZ;

    // Master reference clock counts as absent after this long without an edge
    localparam int MCLK_LOSS_NS     = 2_000;
    localparam int MCLK_LOSS_CYCLES = MCLK_LOSS_NS / CLK_PERIOD_NS;

    // Loss-of-signal defaults, in bit periods
    localparam int LOS_ZERO_BITS    = 32;
    localparam int LOS_WIN_BITS     = 32;
    localparam int LOS_ONES_MIN     = 4;

    // Recovered-bit buffer: {channel, positive, negative}
    localparam int FIFO_DEPTH       = 16;
    localparam int WORD_W           = CH_W + 2;

    typedef enum logic [1:0] {
        RCO_POWER_DOWN,
        RCO_DATA_REC,
        RCO_CLOCK_REC
    } rco_mode_t;

endpackage : rco_pkg

// >>> hw/rco_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and a synchronous flush.
 * Assumes a single clock; read data is valid whenever o_out_valid is high.
 */
module rco_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_flush,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("rco_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire push = i_in_valid & o_in_ready;
    wire pop  = o_out_valid & i_out_ready;

    assign o_in_ready  = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count  <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : rco_fifo

// >>> verif/rco_receive_out_monitor.sv
/* Checker bound to the receive output block: modes, enables, loss flag, host wait.
   Assumes it sees only the block's ports. */
module rco_receive_monitor #(
    parameter int BIT_CYC   = 24,
    parameter int ZERO_BITS = 4
) (
    input wire logic       i_ref_clk,
    input wire logic       i_rst_n,
    input wire logic       i_master_reference_clock,
    input wire logic       i_clock_edge_select,
    input wire logic [7:0] i_line_pos,
    input wire logic [7:0] i_line_neg,
    input wire logic       i_host_wait_req,
    input wire logic [7:0] o_recovered_clock_out,
    input wire logic [7:0] o_recovered_clock_oe,
    input wire logic [7:0] o_positive_rail_data,
    input wire logic [7:0] o_positive_rail_oe,
    input wire logic [7:0] o_negative_rail_data,
    input wire logic [7:0] o_negative_rail_oe,
    input wire logic [7:0] o_signal_loss_flag,
    input wire logic       o_host_wait_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    import rco_pkg::*;
    localparam int LOS_LIM = BIT_CYC * (ZERO_BITS + 3);
    logic [7:0]  quiet;
    logic [11:0] idle0;
    logic        mclk_q;
    wire         clk_mode = quiet < 8'h32;
    wire         line0    = i_line_pos[0] | i_line_neg[0];
    // Saturating, so a long-held master level stays recognisable
    always_ff @(posedge i_ref_clk) begin
        mclk_q <= i_master_reference_clock;
        if (!i_rst_n) quiet <= 8'hFF;
        else if (mclk_q != i_master_reference_clock) quiet <= 8'h00;
        else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
        idle0 <= (!clk_mode || line0) ? 12'h000 : idle0 + 12'h001;
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // Level must also be unchanged on this edge; quiet still shows the old hold there
    sequence s_high; i_master_reference_clock && mclk_q && quiet >= 8'h6E; endsequence
    sequence s_low; !i_master_reference_clock && !mclk_q && quiet >= 8'h6E; endsequence
    // Margin past the mode switch so the lagging mode register has settled
    sequence s_run; clk_mode && $past(clk_mode, 4); endsequence
    a_power_down_hiz: assert property (s_low |->
        (o_recovered_clock_oe | o_positive_rail_oe | o_negative_rail_oe) == 8'h00)
        else $error("enable high while master held low");
    a_data_xor: assert property (s_high |->
        o_recovered_clock_oe == 8'hFF && o_recovered_clock_out == (o_positive_rail_data ^ o_negative_rail_data))
        else $error("data mode clock is not rail xor");
    a_data_polarity: assert property (s_high |->
        o_positive_rail_data == ($past(i_line_pos) ^ {8{!$past(i_clock_edge_select)}})
        && o_negative_rail_data == ($past(i_line_neg) ^ {8{!$past(i_clock_edge_select)}}))
        else $error("data mode rail polarity wrong");
    a_wait_absent: assert property (quiet >= 8'h6E |-> !o_host_wait_ack)
        else $error("host wait while master absent");
    a_wait_follow: assert property (s_run |-> o_host_wait_ack == $past(i_host_wait_req))
        else $error("host wait does not follow request");
    a_clock_enable: assert property (s_run |-> o_recovered_clock_oe == 8'hFF)
        else $error("clock mode output not driven");
    a_launch_edge: assert property (s_run ##0 $changed(o_positive_rail_data[0]) |->
        $changed(o_recovered_clock_out[0]) && o_recovered_clock_out[0] == i_clock_edge_select)
        else $error("rail changed off launch edge");
    a_loss_on_zeros: assert property (idle0 >= LOS_LIM |-> o_signal_loss_flag[0])
        else $error("loss flag low after silence");
endmodule : rco_receive_monitor

bind rco_receive_out rco_receive_monitor #(.BIT_CYC(BIT_CYC), .ZERO_BITS(ZERO_BITS)) u_mon (
    .i_ref_clk, .i_rst_n, .i_master_reference_clock, .i_clock_edge_select, .i_line_pos,
    .i_line_neg, .i_host_wait_req, .o_recovered_clock_out, .o_recovered_clock_oe,
    .o_positive_rail_data, .o_positive_rail_oe, .o_negative_rail_data, .o_negative_rail_oe,
    .o_signal_loss_flag, .o_host_wait_ack
);

// >>> verif/rco_framer_model.sv
/* Framer on channel 0: counts marks sampled on the recovered clock edge
   opposite the launch edge. Assumes rails mean nothing while not enabled. */
module rco_framer_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_edge_select,
    input  wire logic       i_rclk,
    input  wire logic       i_oe,
    input  wire logic       i_pos,
    input  wire logic       i_neg,
    output logic [7:0]      o_ones
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rclk_q;
    // Half a bit after launch, so the rail has settled
    wire  sample = i_oe && rclk_q != i_rclk && i_rclk != i_edge_select;
    always_ff @(posedge i_ref_clk) begin
        rclk_q <= i_rclk;
        if (!i_rst_n) o_ones <= 8'h00;
        else if (sample && (i_pos || i_neg)) o_ones <= o_ones + 8'h01;
    end
endmodule : rco_framer_model

// >>> verif/rco_receive_out_bench.sv
/* Bench for the receive output block: clock and data recovery, power down,
   loss flags, host wait. Assumes shortened loss counts and a 50 MHz clock. */
module rco_receive_out_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rco_pkg::*;
    localparam int ZB = 4;
    localparam int WB = 8;
    logic        i_ref_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        mref = 1'b0;
    logic        run = 1'b0;
    logic        level = 1'b0;
    logic        cke = 1'b1;
    logic [7:0]  i_line_pos = 8'h00;
    logic [7:0]  i_line_neg = 8'h00;
    logic        i_host_wait_req = 1'b0;
    logic [7:0]  o_recovered_clock_out, o_recovered_clock_oe, o_positive_rail_data;
    logic [7:0]  o_positive_rail_oe, o_negative_rail_data, o_negative_rail_oe;
    logic [7:0]  o_signal_loss_flag, ones, ones_start;
    logic        o_host_wait_ack;
    logic [4:0]  tick = 5'h00;
    logic [15:0] notes[$];
    int          seed = 88288;
    int          err_count = 0;
    int          samples_checked = 0;

    always #10 i_ref_clk = ~i_ref_clk;
    // Near the E1 rate while running, else a held level
    always @(negedge i_ref_clk) begin
        tick <= (tick == 5'h0B) ? 5'h00 : tick + 5'h01;
        if (!run) mref <= level;
        else if (tick == 5'h0B) mref <= ~mref;
    end

    rco_receive_out #(.ZERO_BITS(ZB), .WIN_BITS(WB), .ONES_MIN(2)) dut (
        .i_ref_clk, .i_rst_n, .i_master_reference_clock(mref), .i_clock_edge_select(cke),
        .i_line_pos, .i_line_neg, .i_host_wait_req, .o_recovered_clock_out,
        .o_recovered_clock_oe, .o_positive_rail_data, .o_positive_rail_oe,
        .o_negative_rail_data, .o_negative_rail_oe, .o_signal_loss_flag, .o_host_wait_ack
    );
    rco_framer_model u_framer (
        .i_ref_clk, .i_rst_n, .i_edge_select(cke), .i_rclk(o_recovered_clock_out[0]),
        .i_oe(o_recovered_clock_oe[0]), .i_pos(o_positive_rail_data[0]),
        .i_neg(o_negative_rail_data[0]), .o_ones(ones)
    );

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check8

    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // One pulse per bit period on every channel, or silence
    task automatic send_bits(input int n, input logic dense);
        logic [7:0] r;
        for (int b = 0; b < n; b++) begin
            @(negedge i_ref_clk);
            r = $random(seed);
            i_line_pos <= dense ? r : 8'h00;
            i_line_neg <= dense ? ~r : 8'h00;
            i_host_wait_req <= r[0];
            @(negedge i_ref_clk);
            i_line_pos <= 8'h00;
            i_line_neg <= 8'h00;
            repeat (BIT_CYCLES - 2) @(negedge i_ref_clk);
        end
    endtask : send_bits

    task automatic data_burst(input int n);
        logic [7:0] p, q;
        for (int i = 0; i < n; i++) begin
            @(negedge i_ref_clk);
            p = $random(seed);
            q = $random(seed);
            i_line_pos <= p;
            i_line_neg <= q;
            notes.push_back({p ^ {8{~cke}}, q ^ {8{~cke}}});
        end
        @(negedge i_ref_clk);
    endtask : data_burst

    // Results land one edge after the sample
    always @(posedge i_ref_clk) begin
        logic [15:0] note;
        #2;
        if (notes.size() > 0) begin
            note = notes.pop_front();
            check8("positive rail", note[15:8], o_positive_rail_data);
            check8("negative rail", note[7:0], o_negative_rail_data);
            check8("rail xor clock", note[15:8] ^ note[7:0], o_recovered_clock_out);
        end
    end

    initial begin
        #400_000;
        err_count++;
        complete_run();
    end

    initial begin
        repeat (8) @(negedge i_ref_clk);
        check8("enable in reset", 8'h00, o_recovered_clock_oe);
        check8("loss in reset", 8'h00, o_signal_loss_flag);
        i_rst_n <= 1'b1;
        for (int e = 1; e >= 0; e--) begin
            cke <= e[0];
            run <= 1'b1;
            send_bits(WB + 12, 1'b1);
            check8("clock mode enable", 8'hFF, o_recovered_clock_oe);
            check8("loss with ones", 8'h00, o_signal_loss_flag);
            i_host_wait_req <= 1'b1;
            repeat (3) @(negedge i_ref_clk);
            check8("host wait running", 8'h01, {7'h00, o_host_wait_ack});
            send_bits(ZB + 4, 1'b0);
            check8("loss on silence", 8'hFF, o_signal_loss_flag);
            ones_start = ones;
            send_bits(2 * WB + 4, 1'b1);
            check8("loss self clears", 8'h00, o_signal_loss_flag);
            check8("framer marks", 8'h01, {7'h00, ones - ones_start >= 8'h02});
            run <= 1'b0;
            level <= 1'b1;
            i_host_wait_req <= 1'b1;
            repeat (120) @(negedge i_ref_clk);
            check8("host wait absent", 8'h00, {7'h00, o_host_wait_ack});
            data_burst(40);
            level <= 1'b0;
            repeat (120) @(negedge i_ref_clk);
            check8("power down enables", 8'h00,
                   o_recovered_clock_oe | o_positive_rail_oe | o_negative_rail_oe);
            check8("power down clock enable", 8'h00, o_recovered_clock_oe);
        end
        complete_run();
    end
endmodule : rco_receive_out_bench
